/* File: design/sde_ecc.sv */
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/10ps
`include "sde_ecc_map.svh"
module sde_ecc
	import sde_pkg::*;
#(
	parameter bit ECC_ENABLE = 1'b1,  // 0 passes data straight through
	parameter bit LOCAL_MM   = 1'b0   // 1: stall shown as wait request
)
(
	// clock, reset, enable
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	input  wire logic                   ce,
	// register port
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [11:0]            paddr,
	input  wire logic [31:0]            pwdata,
	output logic                        pready,
	output logic [31:0]                 prdata,
	output logic                        pslverr,
	// local data port
	input  wire logic                   local_read,
	input  wire logic                   local_write,
	input  wire logic [`SDE_ADDR_W-1:0] local_addr,
	input  wire logic [`SDE_DATA_W-1:0] local_wdata,
	input  wire logic [`SDE_BE_W-1:0]   local_be,
	output logic                        local_stall,
	output logic [`SDE_DATA_W-1:0]      local_rdata,
	output logic                        local_rvalid,
	output logic                        local_rerr,
	// memory controller port
	output logic                        mem_read,
	output logic                        mem_write,
	output logic [`SDE_ADDR_W-1:0]      mem_addr,
	output logic [`SDE_CW_W-1:0]        mem_wdata,
	input  wire logic                   mem_wait,
	input  wire logic [`SDE_CW_W-1:0]   mem_rdata,
	input  wire logic                   mem_rvalid,
	// interrupt
	output logic                        irq
);

	// ============================================================
	// codec functions
	// hamming over positions 1..71, powers of two hold parity, bit 0 overall
	function automatic logic [71:0] enc_lane(input logic [63:0] d);
		logic [71:0] c;
		logic        par;
		int          j;
		c = '0;
		j = 0;
		for (int p = 1; p < 72; p++)
			if ((p & (p - 1)) != 0)
			begin
				c[p] = d[j];
				j++;
			end
		for (int k = 0; k < 7; k++)
		begin
			par = 1'b0;
			for (int p = 1; p < 72; p++)
				if (((p >> k) & 1) == 1)
					par = par ^ c[p];
			c[1 << k] = par;
		end
		c[0] = ^c[71:1];
		return c;
	endfunction

	function automatic sde_dec_type dec_lane(input logic [71:0] cw);
		sde_dec_type r;
		logic [71:0] c;
		logic [6:0]  s;
		logic        ov;
		int          j;
		c = cw;
		s = '0;
		for (int k = 0; k < 7; k++)
			for (int p = 1; p < 72; p++)
				if (((p >> k) & 1) == 1)
					s[k] = s[k] ^ c[p];
		ov = ^c;
		// odd overall parity with a legal position is one flipped bit
		if (ov && s != 7'h00 && s < 7'h48)
			c[s] = ~c[s];
		r.sbe = ov && (s < 7'h48);
		r.dbe = (!ov && s != 7'h00) || (ov && s >= 7'h48);
		r.syn = {ov, s};
		r.data = '0;
		j = 0;
		for (int p = 1; p < 72; p++)
			if ((p & (p - 1)) != 0)
			begin
				r.data[j] = c[p];
				j++;
			end
		return r;
	endfunction

	function automatic logic [`SDE_CNT_W-1:0] sat_add(input logic [`SDE_CNT_W-1:0] a,
		input logic [1:0] n);
		logic [`SDE_CNT_W:0] s;
		s = {1'b0, a} + {{(`SDE_CNT_W-1){1'b0}}, n};
		return s[`SDE_CNT_W] ? `SDE_CNT_MAX : s[`SDE_CNT_W-1:0];
	endfunction

	// ============================================================
	// state
	sde_state_type                state_q;
	logic                         ready_q;
	logic [`SDE_ADDR_W-1:0]       addr_q;
	logic [`SDE_DATA_W-1:0]       pend_data_q;
	logic [`SDE_BE_W-1:0]         pend_be_q;
	logic [7:0]                   ctrl_q;
	logic [`SDE_CNT_W-1:0]        sbe_th_q, dbe_th_q, sbe_cnt_q, dbe_cnt_q;
	logic [4:0]                   sts_q;
	logic                         logged_q, log_type_q;
	logic [7:0]                   log_syn_q;
	logic [`SDE_ADDR_W-1:0]       log_addr_q;
	logic                         mem_read_q, mem_write_q, rvalid_q, rerr_q, irq_q;
	logic [`SDE_CW_W-1:0]         mem_wdata_q;
	logic [`SDE_DATA_W-1:0]       rdata_q;
	logic                         pready_q, pslverr_q;
	logic [31:0]                  prdata_q;

	// ============================================================
	// decode of returned codewords, one lane per 64 bits
	logic [`SDE_DATA_W-1:0] dec_data;
	logic [1:0]             n_sbe, n_dbe;
	logic [7:0]             first_syn;
	logic [`SDE_DATA_W-1:0] merged;
	logic [`SDE_CW_W-1:0]   enc_word;
	logic [`SDE_DATA_W-1:0] wr_src;
	sde_dec_type            dl;
	always_comb
	begin
		dec_data = '0;
		n_sbe = 2'd0;
		n_dbe = 2'd0;
		first_syn = 8'h00;
		dl = '0;
		for (int l = 0; l < `SDE_LANES; l++)
		begin
			if (ECC_ENABLE)
				dl = dec_lane(mem_rdata[l*72 +: 72]);
			else
				dl = '{data: mem_rdata[l*72 +: 64], sbe: 1'b0, dbe: 1'b0, syn: 8'h00};
			dec_data[l*64 +: 64] = dl.data;
			n_sbe = n_sbe + {1'b0, dl.sbe};
			n_dbe = n_dbe + {1'b0, dl.dbe};
			if ((dl.sbe || dl.dbe) && first_syn == 8'h00)
				first_syn = dl.syn;
		end
	end

	// byte merge for partial writes, then encode toward memory
	always_comb
	begin
		for (int b = 0; b < `SDE_BE_W; b++)
			merged[b*8 +: 8] = pend_be_q[b] ? pend_data_q[b*8 +: 8] : dec_data[b*8 +: 8];
		wr_src = (state_q == ST_RMW) ? merged : local_wdata;
		for (int l = 0; l < `SDE_LANES; l++)
			if (ECC_ENABLE)
				enc_word[l*72 +: 72] = enc_lane(wr_src[l*64 +: 64]);
			else
				enc_word[l*72 +: 72] = {8'h00, wr_src[l*64 +: 64]};
		// corruption lands in lane 0 only, enough for a self test
		if (ctrl_q[`SDE_CTRL_INJ_S] || ctrl_q[`SDE_CTRL_INJ_D])
			enc_word[`SDE_INJ_BIT_A] = ~enc_word[`SDE_INJ_BIT_A];
		if (ctrl_q[`SDE_CTRL_INJ_D])
			enc_word[`SDE_INJ_BIT_B] = ~enc_word[`SDE_INJ_BIT_B];
	end

	// ============================================================
	// local port sequencer
	logic acc_rd, acc_wr, full_wr, ret_rd, ret_rmw;
	assign acc_wr = ready_q && local_write;
	assign acc_rd = ready_q && local_read && !local_write;
	assign full_wr = acc_wr && (&local_be);
	assign ret_rd = (state_q == ST_RD) && mem_rvalid;
	assign ret_rmw = (state_q == ST_RMW) && mem_rvalid;

	// one access in flight keeps the error address exact, at some throughput cost
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_q <= ST_IDLE;
			ready_q <= 1'b0;
			addr_q <= '0;
			pend_data_q <= '0;
			pend_be_q <= '0;
			mem_read_q <= 1'b0;
			mem_write_q <= 1'b0;
			mem_wdata_q <= '0;
		end
		else if (ce)
		begin
			if (mem_read_q && !mem_wait)
				mem_read_q <= 1'b0;
			case (state_q)
				ST_IDLE:
				begin
					ready_q <= 1'b1;
					if (full_wr)
					begin
						addr_q <= local_addr;
						mem_wdata_q <= enc_word;
						mem_write_q <= 1'b1;
						ready_q <= 1'b0;
						state_q <= ST_WR;
					end
					else if (acc_wr)
					begin
						addr_q <= local_addr;
						pend_data_q <= local_wdata;
						pend_be_q <= local_be;
						mem_read_q <= 1'b1;
						ready_q <= 1'b0;
						state_q <= ST_RMW;
					end
					else if (acc_rd)
					begin
						addr_q <= local_addr;
						mem_read_q <= 1'b1;
						ready_q <= 1'b0;
						state_q <= ST_RD;
					end
				end
				ST_WR:
					if (!mem_wait)
					begin
						mem_write_q <= 1'b0;
						ready_q <= 1'b1;
						state_q <= ST_IDLE;
					end
				ST_RD:
					if (mem_rvalid)
					begin
						ready_q <= 1'b1;
						state_q <= ST_IDLE;
					end
				ST_RMW:
					if (mem_rvalid)
					begin
						if (n_dbe != 2'd0)
						begin
							ready_q <= 1'b1;
							state_q <= ST_IDLE;
						end
						else
						begin
							mem_wdata_q <= enc_word;
							mem_write_q <= 1'b1;
							state_q <= ST_WR;
						end
					end
				default:
					state_q <= ST_IDLE;
			endcase
		end
	end

	// returned data with its error flag, one clock after the controller
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rvalid_q <= 1'b0;
			rerr_q <= 1'b0;
			rdata_q <= '0;
		end
		else if (ce)
		begin
			rvalid_q <= ret_rd;
			if (ret_rd)
			begin
				rdata_q <= dec_data;
				rerr_q <= (n_dbe != 2'd0);
			end
		end
	end

	// ============================================================
	// error counters and log
	logic                  any_ret;
	logic [`SDE_CNT_W-1:0] sbe_nxt, dbe_nxt;
	logic [4:0]            sts_set, sts_clr;
	logic                  ap_wr;
	assign any_ret = ret_rd || ret_rmw;
	assign sbe_nxt = sat_add(sbe_cnt_q, n_sbe);
	assign dbe_nxt = sat_add(dbe_cnt_q, n_dbe);
	assign ap_wr = psel && penable && pready_q && pwrite;
	assign sts_clr = (ap_wr && paddr == `SDE_OFS_STATUS) ? pwdata[4:0] : 5'h00;
	// threshold hit when this increment carries the count onto or past it
	always_comb
	begin
		sts_set = 5'h00;
		if (any_ret)
		begin
			sts_set[`SDE_ST_SBE] = (n_sbe != 2'd0);
			sts_set[`SDE_ST_DBE] = (n_dbe != 2'd0);
			sts_set[`SDE_ST_SBE_TH] = (n_sbe != 2'd0) && (sbe_cnt_q < sbe_th_q)
				&& (sbe_nxt >= sbe_th_q);
			sts_set[`SDE_ST_DBE_TH] = (n_dbe != 2'd0) && (dbe_cnt_q < dbe_th_q)
				&& (dbe_nxt >= dbe_th_q);
			sts_set[`SDE_ST_RMW_DBE] = ret_rmw && (n_dbe != 2'd0);
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sbe_cnt_q <= '0;
			dbe_cnt_q <= '0;
			sts_q <= `SDE_ST_RST;
		end
		else if (ce)
		begin
			if (any_ret)
			begin
				sbe_cnt_q <= sbe_nxt;
				dbe_cnt_q <= dbe_nxt;
			end
			sts_q <= (sts_q & ~sts_clr) | sts_set;
		end
	end

	// error log: first error held until cleared, or always the latest
	logic log_now;
	assign log_now = any_ret && (n_sbe != 2'd0 || n_dbe != 2'd0)
		&& (ctrl_q[`SDE_CTRL_LATEST] || !logged_q);
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			logged_q <= 1'b0;
			log_type_q <= 1'b0;
			log_syn_q <= 8'h00;
			log_addr_q <= '0;
		end
		else if (ce)
		begin
			if (log_now)
			begin
				logged_q <= 1'b1;
				log_type_q <= (n_dbe != 2'd0);
				log_syn_q <= first_syn;
				log_addr_q <= addr_q;
			end
			else if (ap_wr && paddr == `SDE_OFS_STATUS && pwdata[`SDE_ST_LOGGED])
				logged_q <= 1'b0;
		end
	end

	// counter interrupts masked separately from the event interrupts
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_q <= 1'b0;
		else if (ce)
			irq_q <= |(sts_q & ~ctrl_q[`SDE_CTRL_MSK_HI:`SDE_CTRL_MSK_LO]);
	end

	// ============================================================
	// register port: one wait state, data taken at the access edge
	logic        mapped;
	logic [31:0] rd_mux;
	always_comb
	begin
		mapped = 1'b1;
		rd_mux = 32'h0000_0000;
		case (paddr)
			`SDE_OFS_CTRL:   rd_mux[7:0] = ctrl_q;
			`SDE_OFS_SBE_TH: rd_mux[15:0] = sbe_th_q;
			`SDE_OFS_DBE_TH: rd_mux[15:0] = dbe_th_q;
			`SDE_OFS_STATUS: rd_mux = {8'h00, log_syn_q, 6'h00, log_type_q, logged_q,
				3'h0, sts_q};
			`SDE_OFS_ADDR:   rd_mux[`SDE_ADDR_W-1:0] = log_addr_q;
			`SDE_OFS_SBE_CT: rd_mux[15:0] = sbe_cnt_q;
			`SDE_OFS_DBE_CT: rd_mux[15:0] = dbe_cnt_q;
			default:         mapped = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end
		else if (ce)
		begin
			pready_q <= psel && penable && !pready_q;
			pslverr_q <= psel && penable && !pready_q && !mapped;
			prdata_q <= (psel && !pwrite && mapped) ? rd_mux : 32'h0000_0000;
		end
	end

	// configuration writes
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_q <= `SDE_CTRL_RST;
			sbe_th_q <= '0;
			dbe_th_q <= '0;
		end
		else if (ce && ap_wr)
		begin
			case (paddr)
				`SDE_OFS_CTRL:   ctrl_q <= pwdata[7:0];
				`SDE_OFS_SBE_TH: sbe_th_q <= pwdata[15:0];
				`SDE_OFS_DBE_TH: dbe_th_q <= pwdata[15:0];
				default:         ctrl_q <= ctrl_q;
			endcase
		end
	end

	// ============================================================
	// outputs
	assign pready = pready_q;
	assign prdata = prdata_q;
	assign pslverr = pslverr_q;
	assign local_stall = LOCAL_MM ? !ready_q : ready_q;
	assign local_rdata = rdata_q;
	assign local_rvalid = rvalid_q;
	assign local_rerr = rerr_q;
	assign mem_read = mem_read_q;
	assign mem_write = mem_write_q;
	assign mem_addr = addr_q;
	assign mem_wdata = mem_wdata_q;
	assign irq = irq_q;

	// ============================================================
	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	AST_WR_LATENCY: assert property (ce && full_wr && state_q == ST_IDLE |=> mem_write_q)
		else $error("full write not issued one clock after acceptance");
	AST_RD_LATENCY: assert property (ce && ret_rd |=> rvalid_q && rdata_q == $past(dec_data))
		else $error("read data not returned one clock after memory");
	AST_ERR_FLAG: assert property (ce && ret_rd && n_dbe != 2'd0 |=> rvalid_q && rerr_q)
		else $error("double error not flagged with data");
	AST_SBE_COUNT: assert property (ce && any_ret && n_sbe == 2'd1
		&& sbe_cnt_q != `SDE_CNT_MAX |=> sbe_cnt_q == $past(sbe_cnt_q) + 16'h0001)
		else $error("single error counter did not step by one");
	AST_SATURATE: assert property (ce && dbe_cnt_q == `SDE_CNT_MAX |=> dbe_cnt_q == `SDE_CNT_MAX)
		else $error("double error counter wrapped");
	AST_RMW_STALL: assert property (ce && acc_wr && !full_wr && state_q == ST_IDLE
		|=> !ready_q && mem_read_q && state_q == ST_RMW)
		else $error("partial write did not stall and read");
	AST_RMW_DISCARD: assert property (ce && ret_rmw && n_dbe != 2'd0
		|=> !mem_write_q && state_q == ST_IDLE && sts_q[`SDE_ST_RMW_DBE])
		else $error("partial write kept despite double error");
	AST_W1C_ZERO: assert property (ce && ap_wr && paddr == `SDE_OFS_STATUS && pwdata[4:0] == 5'h00
		|=> (sts_q & $past(sts_q)) == $past(sts_q))
		else $error("writing zero cleared a status bit");
	AST_TH_HIT: assert property (ce && any_ret && n_dbe != 2'd0 && dbe_nxt == dbe_th_q
		&& dbe_cnt_q < dbe_th_q |=> sts_q[`SDE_ST_DBE_TH])
		else $error("double threshold not flagged on equality");
	AST_MASK: assert property (ce && sts_q != 5'h00 && ctrl_q[5:1] == 5'h00 |=> irq_q)
		else $error("unmasked cause did not raise interrupt");

endmodule // sde_ecc

/* File: common/sde_ecc_map.svh */
`ifndef SDE_ECC_MAP_SVH
`define SDE_ECC_MAP_SVH
// Summary of operation
// - encode 64 data bits into 72-bit codeword
// - correct single-bit errors on returned words
// - detect double-bit errors and count them
// - write path adds one clock of delay
// - read path adds one clock of delay
// - five interrupt causes, single/double event/threshold, double error during merge
// - thresholds and first-or-latest capture are writable
// - optional injected corruption of stored codewords
// - status holds address, error type, syndrome
// - error flag travels with returned data word
// - separate single-bit and double-bit counters
// - one codec lane per 64 data bits
// - N x 64 local port, native or mapped
// - 32-bit register port for config and status
// - N x 72 master port toward memory controller
// - codec removable by build parameter
// - counters add one per erroring lane
// - interrupt when counter reaches threshold
// - write one clears status, zero keeps it
// - separate masks for the two counter interrupts
// - partial write does stalled read-modify-write
// - double error during merge discards the write
// ============================================================
// sizes
`define SDE_LANES      2
`define SDE_DATA_W     128
`define SDE_CW_W       144
`define SDE_BE_W       16
`define SDE_ADDR_W     24
`define SDE_CNT_W      16
`define SDE_CNT_MAX    16'hffff
// ============================================================
// register byte offsets
`define SDE_OFS_CTRL   12'h000
`define SDE_OFS_SBE_TH 12'h004
`define SDE_OFS_DBE_TH 12'h008
`define SDE_OFS_STATUS 12'h00c
`define SDE_OFS_ADDR   12'h010
`define SDE_OFS_SBE_CT 12'h014
`define SDE_OFS_DBE_CT 12'h018
// ============================================================
// control fields
`define SDE_CTRL_LATEST 0
`define SDE_CTRL_MSK_LO 1
`define SDE_CTRL_MSK_HI 5
`define SDE_CTRL_INJ_S  6
`define SDE_CTRL_INJ_D  7
`define SDE_CTRL_RST    8'h00
// status fields; bits 4:0 are interrupt causes
`define SDE_ST_SBE      0
`define SDE_ST_DBE      1
`define SDE_ST_SBE_TH   2
`define SDE_ST_DBE_TH   3
`define SDE_ST_RMW_DBE  4
`define SDE_ST_LOGGED   8
`define SDE_ST_TYPE     9
`define SDE_ST_SYN_LO   16
`define SDE_ST_RST      5'h00
// codeword bits flipped by injection
`define SDE_INJ_BIT_A   3
`define SDE_INJ_BIT_B   5
`endif

/* File: common/sde_pkg.sv */
package sde_pkg;
	// ============================================================
	// sequencer states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_WR,
		ST_RD,
		ST_RMW
	} sde_state_type;

	// per-lane decode result
	typedef struct packed {
		logic [63:0] data;
		logic        sbe;
		logic        dbe;
		logic [7:0]  syn;
	} sde_dec_type;
endpackage

/* File: testbench/sde_mem_model.sv */
`timescale 1ns/10ps
// ====================
// memory controller stand-in
module sde_mem_model
(
	// clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// bench controls: random stalls, corrupted read data
	input  wire logic         slow,
	input  wire logic [143:0] flip,
	// master port of the block
	input  wire logic         mem_read,
	input  wire logic         mem_write,
	input  wire logic [23:0]  mem_addr,
	input  wire logic [143:0] mem_wdata,
	output logic              mem_wait,
	output logic [143:0]      mem_rdata,
	output logic              mem_rvalid
);
	logic [143:0] mem_q [16];
	logic [3:0]   idx_q;
	logic [1:0]   pend_q;
	int           seed = 21223;

	// one read in flight; data outside the valid cycle keeps changing
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			mem_wait <= 1'b0;
			mem_rvalid <= 1'b0;
			mem_rdata <= '0;
			pend_q <= 2'h0;
			idx_q <= 4'h0;
		end
		else
		begin
			mem_wait <= slow & 1'($random(seed));
			mem_rvalid <= pend_q == 2'h1;
			mem_rdata <= (pend_q == 2'h1) ? mem_q[idx_q] ^ flip : ~mem_rdata;
			if (pend_q != 2'h0)
				pend_q <= pend_q - 2'h1;
			if (mem_read && !mem_wait)
			begin
				idx_q <= mem_addr[3:0];
				pend_q <= 2'h3;
			end
		end

	// storage; a write lands only when not stalled
	always_ff @(posedge pclk)
		if (mem_write && !mem_wait)
			mem_q[mem_addr[3:0]] <= mem_wdata;
endmodule  // sde_mem_model

/* File: testbench/testbench.sv */
`timescale 1ns/10ps
`include "sde_ecc_map.svh"
module testbench;
	logic         pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, irq;
	logic [11:0]  paddr;
	logic [31:0]  pwdata, prdata, rd;
	logic         local_read, local_write, local_stall, local_rvalid, local_rerr;
	logic [23:0]  local_addr, mem_addr;
	logic [127:0] local_wdata, local_rdata, dat, nd;
	logic [15:0]  local_be, be;
	logic         mem_read, mem_write, mem_wait, mem_rvalid, er, slow;
	logic [143:0] mem_wdata, mem_rdata, flip;
	logic [127:0] shadow [8];
	int           mismatches, n_checks, seed, k;

	sde_ecc #(.ECC_ENABLE(1'b1), .LOCAL_MM(1'b0)) dut (.pclk, .presetn, .ce, .psel, .penable,
		.pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .local_read, .local_write,
		.local_addr, .local_wdata, .local_be, .local_stall, .local_rdata, .local_rvalid,
		.local_rerr, .mem_read, .mem_write, .mem_addr, .mem_wdata, .mem_wait, .mem_rdata,
		.mem_rvalid, .irq);

	sde_mem_model mem (.pclk, .presetn, .slow, .flip, .mem_read, .mem_write, .mem_addr,
		.mem_wdata, .mem_wait, .mem_rdata, .mem_rvalid);

	// ====================
	// helpers
	task automatic give_verdict();
		if (mismatches == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input logic [127:0] got, exp);
		n_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// bounded wait; a hang ends the run
	task automatic bound(inout int n);
		n++;
		if (n > 400)
		begin
			mismatches++;
			$display("[FAIL] %0t wait timed out", $time);
			give_verdict();
		end
	endtask

	function automatic logic [127:0] rnd();
		return {$random(seed), $random(seed), $random(seed), $random(seed)};
	endfunction

	function automatic logic [127:0] merge(logic [127:0] o, n, logic [15:0] m);
		for (int b = 0; b < 16; b++)
			if (m[b])
				o[b*8 +: 8] = n[b*8 +: 8];
		return o;
	endfunction

	// register access; an idle edge follows so psel is never set twice at one edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			bound(n);
		end
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic rchk(input logic [11:0] a, input logic [31:0] m, e);
		apb(1'b0, a, 32'h0);
		chk({er, rd & m}, {1'b0, e});
	endtask

	task automatic ichk(input logic e);
		repeat (3) @(posedge pclk);
		chk(irq, e);
	endtask

	// one local access, held until the ready indicator takes it
	task automatic lop(input logic w, input int i, input logic [127:0] d, input logic [15:0] m);
		int n = 0;
		logic pv;
		slow <= 1'($random(seed));
		local_write <= w;
		local_read <= !w;
		local_addr <= 24'(i);
		local_wdata <= d;
		local_be <= m;
		do
		begin
			@(posedge pclk);
			bound(n);
		end
		while (local_stall !== 1'b1);
		local_write <= 1'b0;
		local_read <= 1'b0;
		@(posedge pclk);
		chk((w && m == 16'hffff) ? mem_write : mem_read, 1'b1);
		while (local_stall !== 1'b1)
		begin
			pv = mem_rvalid;
			@(posedge pclk);
			bound(n);
			if (local_rvalid === 1'b1)
			begin
				dat = local_rdata;
				er = local_rerr;
				chk(pv, 1'b1);
			end
		end
	endtask

	task automatic rdchk(input int i, input logic [127:0] e, input logic x);
		lop(1'b0, i, 128'h0, 16'h0);
		chk(dat, e);
		chk(er, x);
	endtask

	// ====================
	// clock and watchdog
	initial
	begin
		pclk = 1'b0;
		forever
			#20 pclk = ~pclk;
	end

	initial
	begin
		#(40 * 20000);
		mismatches++;
		give_verdict();
	end

	// ====================
	// main sequence
	initial
	begin
		{presetn, psel, penable, pwrite, paddr, pwdata, local_read, local_write} = '0;
		{local_addr, local_wdata, local_be, slow, flip, mismatches, n_checks} = '0;
		ce = 1'b1;
		seed = 21223;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		// reset values, unmapped refusal, config storage
		for (k = 0; k < 7; k++)
			rchk(12'(4 * k), '1, 32'h0);
		apb(1'b0, 12'h01c, 32'h0);
		chk({er, rd}, {1'b1, 32'h0});
		apb(1'b1, `SDE_OFS_CTRL, 32'hff);
		rchk(`SDE_OFS_CTRL, '1, 32'hff);
		apb(1'b1, `SDE_OFS_SBE_TH, '1);
		rchk(`SDE_OFS_SBE_TH, '1, 32'hffff);
		apb(1'b1, `SDE_OFS_CTRL, 32'h0);
		apb(1'b1, `SDE_OFS_SBE_TH, 32'h3);
		apb(1'b1, `SDE_OFS_DBE_TH, 32'h2);
		// clean random traffic with random stalls
		for (k = 0; k < 8; k++)
		begin
			shadow[k] = rnd();
			lop(1'b1, k, shadow[k], 16'hffff);
		end
		for (k = 0; k < 8; k++)
			rdchk(k, shadow[k], 1'b0);
		// injected single error, first-error logging
		apb(1'b1, `SDE_OFS_CTRL, 32'h40);
		lop(1'b1, 7, shadow[7], 16'hffff);
		apb(1'b1, `SDE_OFS_CTRL, 32'h0);
		rdchk(7, shadow[7], 1'b0);
		rchk(`SDE_OFS_STATUS, 32'hffff, 32'h101);
		rchk(`SDE_OFS_ADDR, '1, 32'h7);
		rchk(`SDE_OFS_SBE_CT, '1, 32'h1);
		// one error in each lane counts twice, reaching the threshold
		flip <= (144'h1 << 10) | (144'h1 << 90);
		rdchk(1, shadow[1], 1'b0);
		flip <= '0;
		rchk(`SDE_OFS_SBE_CT, '1, 32'h3);
		rchk(`SDE_OFS_STATUS, 32'h1f, 32'h5);
		rchk(`SDE_OFS_ADDR, '1, 32'h7);
		ichk(1'b1);
		// write zero keeps, write one clears
		apb(1'b1, `SDE_OFS_STATUS, 32'h0);
		rchk(`SDE_OFS_STATUS, 32'h1f, 32'h5);
		apb(1'b1, `SDE_OFS_STATUS, 32'h1f);
		rchk(`SDE_OFS_STATUS, 32'h1f, 32'h0);
		ichk(1'b0);
		// double error, latest logging
		apb(1'b1, `SDE_OFS_CTRL, 32'h1);
		flip <= 144'h6;
		rdchk(2, shadow[2], 1'b1);
		flip <= '0;
		rchk(`SDE_OFS_STATUS, 32'hffff, 32'h302);
		rchk(`SDE_OFS_ADDR, '1, 32'h2);
		rchk(`SDE_OFS_DBE_CT, '1, 32'h1);
		ichk(1'b1);
		// masked double event and threshold
		apb(1'b1, `SDE_OFS_STATUS, 32'h1f);
		apb(1'b1, `SDE_OFS_CTRL, 32'h15);
		flip <= 144'h3 << 73;
		rdchk(3, shadow[3], 1'b1);
		flip <= '0;
		rchk(`SDE_OFS_STATUS, 32'h1f, 32'ha);
		ichk(1'b0);
		apb(1'b1, `SDE_OFS_CTRL, 32'h1);
		ichk(1'b1);
		apb(1'b1, `SDE_OFS_STATUS, 32'h1f);
		// partial writes, the middle one over a single error
		for (k = 4; k < 7; k++)
		begin
			nd = rnd();
			be = (16'($random(seed)) & 16'h7ffe) | 16'h0010;
			shadow[k] = merge(shadow[k], nd, be);
			flip <= (k == 5) ? 144'h1 << 100 : '0;
			lop(1'b1, k, nd, be);
			flip <= '0;
			rdchk(k, shadow[k], 1'b0);
		end
		// double error during merge drops the write
		flip <= 144'h5;
		lop(1'b1, 4, rnd(), 16'h00ff);
		flip <= '0;
		rdchk(4, shadow[4], 1'b0);
		rchk(`SDE_OFS_STATUS, 32'h1f, 32'h13);
		rchk(`SDE_OFS_DBE_CT, '1, 32'h3);
		rchk(`SDE_OFS_SBE_CT, '1, 32'h4);
		ichk(1'b1);
		// frozen clock enable: a waiting request is not taken
		ce <= 1'b0;
		local_read <= 1'b1;
		repeat (4) @(posedge pclk);
		chk({mem_read, local_stall}, 2'b01);
		local_read <= 1'b0;
		ce <= 1'b1;
		@(posedge pclk);
		give_verdict();
	end
endmodule  // testbench
